// ==== hw/tpm_clk_div.sv ====
// trace clock divider: half and quarter rate outputs
`timescale 1ns/1ps
`default_nettype none
module tpm_clk_div (
  input wire logic sys_clk,
  input wire logic rst,
  output tpm_pkg::tpm_div_e divState,
  output logic halfRateToggle,
  output logic quarterRateClk
);
  import tpm_pkg::*;

  // ----------------------------------------------------------
  // divider
  // ----------------------------------------------------------
  // every flop sits on sys_clk; no flop is clocked by another's output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divState <= TPM_DIV_S0;
      halfRateToggle <= 1'b0;
      quarterRateClk <= 1'b0;
    end else begin
      unique case (divState)
        TPM_DIV_S0: begin
          divState <= TPM_DIV_S1;
          halfRateToggle <= 1'b1;
          quarterRateClk <= 1'b1;
        end
        TPM_DIV_S1: begin
          divState <= TPM_DIV_S2;
          halfRateToggle <= 1'b0;
          quarterRateClk <= 1'b1;
        end
        TPM_DIV_S2: begin
          divState <= TPM_DIV_S3;
          halfRateToggle <= 1'b1;
          quarterRateClk <= 1'b0;
        end
        TPM_DIV_S3: begin
          divState <= TPM_DIV_S0;
          halfRateToggle <= 1'b0;
          quarterRateClk <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_DIV_SEQ: assert property (
    divState == TPM_DIV_S0 |=> divState == TPM_DIV_S1 ##1 divState == TPM_DIV_S2 ##1 divState == TPM_DIV_S3
  ) else $error("divider left its four-state cycle");
  AST_DIV_OUT: assert property (
    (divState == TPM_DIV_S1) |-> (halfRateToggle && quarterRateClk) ##1 (!halfRateToggle && quarterRateClk)
  ) else $error("divider outputs off pattern");
  AST_QTR_ON_HALF_RISE: assert property (
    $changed(quarterRateClk) |-> $rose(halfRateToggle)
  ) else $error("quarter clock moved without half clock rising");
endmodule : tpm_clk_div
`default_nettype wire

// ==== hw/tpm_defines.svh ====
// trace port mux constants: register map, field positions, codes
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH
// ----------------------------------------------------------
// register map
// ----------------------------------------------------------
`define TPM_ADDR_W 8
`define TPM_DATA_W 32
`define TPM_CTRL_ADDR 8'h00
`define TPM_STAT_ADDR 8'h04
`define TPM_CTRL_RST 32'h0000_0000
`define TPM_EN_BIT 0
`define TPM_HALF_BIT 1
`define TPM_MODE_LSB 16
`define TPM_MODE_MSB 17
`define TPM_ST_DIV_LSB 0
`define TPM_ST_DIV_MSB 1
`define TPM_ST_MODE_LSB 2
`define TPM_ST_MODE_MSB 3
`define TPM_ST_ACTIVE 4
`define TPM_ST_JTAG_EN 5
`define TPM_ST_HALF_IGN 6
`define TPM_ST_MODE_BAD 7
`define TPM_ST_RATE_ADV 8
// ----------------------------------------------------------
// mode codes and pin layout
// ----------------------------------------------------------
`define TPM_MODE_NORMAL 2'b00
`define TPM_MODE_MUX 2'b01
`define TPM_MODE_DEMUX 2'b10
`define TPM_PINS 20
`define TPM_MUX_PINS 10
`define TPM_MUX_PAIRS 6
`define TPM_MUX_PKT_BASE 4
// ----------------------------------------------------------
// clock rates in MHz
// ----------------------------------------------------------
`define TPM_CORE_MHZ 100
`define TPM_HALF_ADVISED_MHZ 100
`define TPM_MUX_LIMIT_MHZ 50
`endif

// ==== hw/tpm_pkg.sv ====
// trace port mux types
package tpm_pkg;
  typedef enum logic [1:0] {TPM_NORMAL, TPM_MUX, TPM_DEMUX, TPM_OFF} tpm_mode_e;
  typedef enum logic [1:0] {TPM_DIV_S0, TPM_DIV_S1, TPM_DIV_S2, TPM_DIV_S3} tpm_div_e;
  typedef struct packed {
    logic [15:0] tracePacketBus;
    logic traceSyncFlag;
    logic [2:0] pipelineStatus;
  } tpm_trace_s;
endpackage : tpm_pkg

// ==== hw/tpm_trace_port_mux.sv ====
// trace port pin mapper: normal, multiplexed and demultiplexed modes
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
// What this block does
// - mode code 00 normal, 01 mux, 10 demux
// - full-rate normal, half-rate demux, rising-edge capture
// - normal half-rate: clock halved, both edges sampled
// - demux half-rate: quarter clock, both edges sampled
// - normal mode offers full and half rate
// - mux mode: two signals per pin
// - mux mode ignores half rate, full clock
// - mux pins 0-3: status, packet0 / sync, packet1-3
// - mux pins 4-9: even packet / next odd
// - mux mode advised only below 50 MHz
// - mux data launched from clock root timing
// - demux suits fast systems, uses port B pins as well as port A
// - demux pair: first on B, second on A
// - quarter clock comes glitch-free from flops
// - divider steps 00..11, fixed half/quarter pattern
// - divider flops reset asynchronously to zero
// - divider flops on core clock only
// - trace port fully synchronous to core clock
// - jtag-domain enable passes synchronising flops
module tpm_trace_port_mux #(
  parameter int CORE_MHZ = `TPM_CORE_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`TPM_ADDR_W-1:0] regAddr,
  input wire logic [`TPM_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`TPM_DATA_W-1:0] regRdData,
  input wire tpm_pkg::tpm_trace_s traceIn,
  input wire logic jtagTraceEnable,
  output logic [`TPM_PINS-1:0] pinRise,
  output logic [`TPM_PINS-1:0] pinFall,
  output logic [`TPM_PINS-1:0] portB,
  output logic clkRise,
  output logic clkFall
);
  import tpm_pkg::*;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic tpm_mode_e decodeMode(input logic [1:0] code);
    tpm_mode_e m;
    m = TPM_OFF;
    if (code == `TPM_MODE_NORMAL) m = TPM_NORMAL;
    else if (code == `TPM_MODE_MUX) m = TPM_MUX;
    else if (code == `TPM_MODE_DEMUX) m = TPM_DEMUX;
    return m;
  endfunction : decodeMode

  // one slot of the multiplexed pins; fallSlot picks the falling-edge half
  function automatic logic [`TPM_MUX_PINS-1:0] muxSlot(input tpm_trace_s t, input logic fallSlot);
    logic [`TPM_MUX_PINS-1:0] v;
    v = '0;
    if (!fallSlot) begin
      v[3:0] = {t.tracePacketBus[0], t.pipelineStatus};
    end else begin
      v[3:0] = {t.tracePacketBus[3:1], t.traceSyncFlag};
    end
    for (int i = 0; i < `TPM_MUX_PAIRS; i++) begin
      v[`TPM_MUX_PKT_BASE+i] = t.tracePacketBus[`TPM_MUX_PKT_BASE+2*i+int'(fallSlot)];
    end
    return v;
  endfunction : muxSlot

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic [`TPM_DATA_W-1:0] ctrl_r;
  logic [1:0] modeCode;
  logic traceEn;
  logic halfReq;
  tpm_mode_e mode;
  logic [`TPM_DATA_W-1:0] status;

  assign modeCode = ctrl_r[`TPM_MODE_MSB:`TPM_MODE_LSB];
  assign traceEn = ctrl_r[`TPM_EN_BIT];
  assign halfReq = ctrl_r[`TPM_HALF_BIT];
  assign mode = decodeMode(modeCode);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `TPM_CTRL_RST;
    end else if (regWr && regAddr == `TPM_CTRL_ADDR) begin
      ctrl_r <= '0;
      ctrl_r[`TPM_EN_BIT] <= regWrData[`TPM_EN_BIT];
      ctrl_r[`TPM_HALF_BIT] <= regWrData[`TPM_HALF_BIT];
      ctrl_r[`TPM_MODE_MSB:`TPM_MODE_LSB] <= regWrData[`TPM_MODE_MSB:`TPM_MODE_LSB];
    end
  end

  // ----------------------------------------------------------
  // jtag-domain enable crossing
  // ----------------------------------------------------------
  // a slow core clock makes a disable from the jtag side land a few cycles late
  logic jtagSync1_r;
  logic jtagSync2_r;
  logic jtagSync3_r;
  logic jtagEn_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      jtagSync1_r <= 1'b0;
      jtagSync2_r <= 1'b0;
      jtagSync3_r <= 1'b0;
    end else begin
      jtagSync1_r <= jtagTraceEnable;
      jtagSync2_r <= jtagSync1_r;
      jtagSync3_r <= jtagSync2_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      jtagEn_r <= 1'b0;
    end else if (jtagSync2_r == jtagSync3_r) begin
      jtagEn_r <= jtagSync3_r;
    end
  end

  logic active;
  assign active = traceEn && jtagEn_r && (mode != TPM_OFF);

  // ----------------------------------------------------------
  // trace clock divider
  // ----------------------------------------------------------
  tpm_div_e divState;
  logic halfRateToggle;
  logic quarterRateClk;

  tpm_clk_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .divState(divState),
    .halfRateToggle(halfRateToggle),
    .quarterRateClk(quarterRateClk)
  );

  // ----------------------------------------------------------
  // exported trace clock
  // ----------------------------------------------------------
  // clkRise/clkFall feed a double-rate pad cell on the clock-tree root,
  // so full rate costs no extra flop stage against the data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clkRise <= 1'b0;
      clkFall <= 1'b0;
    end else if (!active) begin
      clkRise <= 1'b0;
      clkFall <= 1'b0;
    end else begin
      unique case (mode)
        TPM_NORMAL: begin
          if (halfReq) begin
            clkRise <= halfRateToggle;
            clkFall <= halfRateToggle;
          end else begin
            clkRise <= 1'b1;
            clkFall <= 1'b0;
          end
        end
        TPM_MUX: begin
          clkRise <= 1'b1;
          clkFall <= 1'b0;
        end
        TPM_DEMUX: begin
          if (halfReq) begin
            clkRise <= quarterRateClk;
            clkFall <= quarterRateClk;
          end else begin
            clkRise <= halfRateToggle;
            clkFall <= halfRateToggle;
          end
        end
        TPM_OFF: begin
          clkRise <= 1'b0;
          clkFall <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // demultiplexed pair capture
  // ----------------------------------------------------------
  tpm_trace_s firstHold_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      firstHold_r <= '0;
    end else if (!halfRateToggle) begin
      firstHold_r <= traceIn;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portB <= '0;
    end else if (!active || mode != TPM_DEMUX) begin
      portB <= '0;
    end else if (halfRateToggle) begin
      portB <= firstHold_r;
    end
  end

  // ----------------------------------------------------------
  // port A pins
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinRise <= '0;
      pinFall <= '0;
    end else if (!active) begin
      pinRise <= '0;
      pinFall <= '0;
    end else begin
      unique case (mode)
        TPM_NORMAL: begin
          pinRise <= traceIn;
          pinFall <= traceIn;
        end
        TPM_MUX: begin
          pinRise <= {{(`TPM_PINS-`TPM_MUX_PINS){1'b0}}, muxSlot(traceIn, 1'b0)};
          pinFall <= {{(`TPM_PINS-`TPM_MUX_PINS){1'b0}}, muxSlot(traceIn, 1'b1)};
        end
        TPM_DEMUX: begin
          if (halfRateToggle) begin
            pinRise <= traceIn;
            pinFall <= traceIn;
          end
        end
        TPM_OFF: begin
          pinRise <= '0;
          pinFall <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // status and read port
  // ----------------------------------------------------------
  logic rateAdvice;
  // flags a mode run above its advised clock rate
  assign rateAdvice = (mode == TPM_MUX && CORE_MHZ >= `TPM_MUX_LIMIT_MHZ)
    || (mode == TPM_NORMAL && !halfReq && CORE_MHZ > `TPM_HALF_ADVISED_MHZ);

  always_comb begin
    status = '0;
    status[`TPM_ST_DIV_MSB:`TPM_ST_DIV_LSB] = divState;
    status[`TPM_ST_MODE_MSB:`TPM_ST_MODE_LSB] = modeCode;
    status[`TPM_ST_ACTIVE] = active;
    status[`TPM_ST_JTAG_EN] = jtagEn_r;
    status[`TPM_ST_HALF_IGN] = halfReq && mode == TPM_MUX;
    status[`TPM_ST_MODE_BAD] = mode == TPM_OFF;
    status[`TPM_ST_RATE_ADV] = rateAdvice;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd && regAddr == `TPM_CTRL_ADDR) begin
      regRdData <= ctrl_r;
    end else if (regRd && regAddr == `TPM_STAT_ADDR) begin
      regRdData <= status;
    end else begin
      regRdData <= '0;
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [`TPM_PINS-1:0] traceFlat;
  assign traceFlat = traceIn;

  AST_CLK_FULL: assert property (
    active && mode == TPM_NORMAL && !halfReq |=> clkRise && !clkFall
  ) else $error("normal full-rate clock wrong");
  AST_CLK_HALF: assert property (
    active && mode == TPM_NORMAL && halfReq |=> clkRise == clkFall && clkRise == $past(halfRateToggle)
  ) else $error("normal half-rate clock wrong");
  AST_CLK_QUARTER: assert property (
    active && mode == TPM_DEMUX && halfReq |=> clkRise == clkFall && clkRise == $past(quarterRateClk)
  ) else $error("demux quarter-rate clock wrong");
  AST_MUX_FULL_RATE: assert property (
    active && mode == TPM_MUX |=> clkRise && !clkFall
  ) else $error("mux clock not at full rate");
  AST_MUX_LOW_PINS: assert property (
    active && mode == TPM_MUX |=> pinRise[3:0] == {$past(traceFlat[4]), $past(traceFlat[2:0])}
      && pinFall[3:0] == {$past(traceFlat[7:5]), $past(traceFlat[3])}
  ) else $error("mux low pins mapped wrong");
  AST_MUX_HIGH_PINS: assert property (
    active && mode == TPM_MUX |=> pinRise[9:4] == {$past(traceFlat[18]), $past(traceFlat[16]),
      $past(traceFlat[14]), $past(traceFlat[12]), $past(traceFlat[10]), $past(traceFlat[8])}
      && pinFall[9:4] == {$past(traceFlat[19]), $past(traceFlat[17]), $past(traceFlat[15]),
      $past(traceFlat[13]), $past(traceFlat[11]), $past(traceFlat[9])} && pinRise[19:10] == '0
  ) else $error("mux high pins mapped wrong");
  AST_DEMUX_PAIR: assert property (
    active && mode == TPM_DEMUX && halfRateToggle
      |=> portB == $past(traceFlat, 2) && pinRise == $past(traceFlat)
  ) else $error("demux pair order wrong");
  AST_DEMUX_HOLD: assert property (
    active && mode == TPM_DEMUX && !halfRateToggle |=> $stable(portB) && $stable(pinRise)
  ) else $error("demux ports moved off the pair boundary");
  AST_SYNC_AGREE: assert property (
    $changed(jtagEn_r) |-> $past(jtagSync2_r) == $past(jtagSync3_r) && jtagEn_r == $past(jtagSync3_r)
  ) else $error("jtag enable taken before synchronisers agree");
  AST_SYNC_LATENCY: assert property (
    $rose(jtagSync1_r) ##1 jtagSync1_r ##1 jtagSync1_r |=> jtagEn_r
  ) else $error("jtag enable not seen in time");
  AST_MODE_MIRROR: assert property (
    regWr && regAddr == `TPM_CTRL_ADDR |=> modeCode == $past(regWrData[`TPM_MODE_MSB:`TPM_MODE_LSB])
  ) else $error("mode field does not mirror the control write");
  AST_PORTB_IDLE: assert property (
    !(active && mode == TPM_DEMUX) |=> portB == '0
  ) else $error("port b driven outside demux mode");
  AST_INACTIVE_QUIET: assert property (
    !active |=> pinRise == '0 && pinFall == '0 && !clkRise && !clkFall
  ) else $error("trace outputs moved while inactive");
  AST_DEMUX_CLK_HALF: assert property (
    active && mode == TPM_DEMUX && !halfReq |=> clkRise == clkFall && clkRise == $past(halfRateToggle)
  ) else $error("demux half-rate clock wrong");

  COV_MUX: cover property (active && mode == TPM_MUX ##1 active && mode == TPM_MUX);
  COV_DEMUX_QUARTER: cover property (active && mode == TPM_DEMUX && halfReq && $rose(quarterRateClk));
  COV_NORMAL_HALF: cover property (active && mode == TPM_NORMAL && halfReq ##2 clkRise);
  COV_JTAG_DISABLE: cover property ($fell(jtagEn_r) && traceEn);
  COV_DEMUX_FULL: cover property (active && mode == TPM_DEMUX && !halfReq ##1 portB != '0);
endmodule : tpm_trace_port_mux
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the trace port pin mapper
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin numErrors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
  import tpm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [`TPM_ADDR_W-1:0] regAddr = 8'h00;
  logic [`TPM_DATA_W-1:0] regWrData = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic jtagTraceEnable = 1'b1;
  logic [`TPM_PINS-1:0] stim = 20'h0_0000;
  logic [`TPM_DATA_W-1:0] regRdData;
  logic [`TPM_DATA_W-1:0] rdVal;
  logic [`TPM_DATA_W-1:0] ctrl;
  logic [`TPM_PINS-1:0] pinRise;
  logic [`TPM_PINS-1:0] pinFall;
  logic [`TPM_PINS-1:0] portB;
  logic clkRise;
  logic clkFall;
  tpm_trace_s muxTrace;
  logic [`TPM_PINS-1:0] demuxB;
  logic [`TPM_PINS-1:0] demuxA;
  logic riseClk;
  logic fallClk;
  logic clkHist [8];
  logic [`TPM_PINS-1:0] bHist [8];
  int numErrors = 0;
  int compares = 0;
  int step;
  always #5 sys_clk = ~sys_clk;
  // an incrementing stream makes every pair and lag visible as a difference
  always @(posedge sys_clk) stim <= stim + 20'h0_0001;
  tpm_trace_port_mux uut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .traceIn(tpm_trace_s'(stim)),
    .jtagTraceEnable(jtagTraceEnable), .pinRise(pinRise), .pinFall(pinFall), .portB(portB),
    .clkRise(clkRise), .clkFall(clkFall));
  tpm_analyser_model an (.sys_clk(sys_clk), .pinRise(pinRise), .pinFall(pinFall), .portB(portB),
    .clkRise(clkRise), .clkFall(clkFall), .muxTrace(muxTrace), .demuxB(demuxB), .demuxA(demuxA),
    .riseClk(riseClk), .fallClk(fallClk));
  // ----------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #8;
  endtask : tick
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : regWrite
  task automatic regRead(input logic [7:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask : regRead
  task automatic wrapUp;
    $display("comparisons %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrapUp
  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    `CHK("pins idle", 20'h0_0000, pinRise)
    `CHK("clock idle", 1'b0, clkRise)
    regRead(`TPM_CTRL_ADDR);
    `CHK("ctrl reset", `TPM_CTRL_RST, rdVal)
    regWrite(`TPM_STAT_ADDR, 32'hFFFF_FFFF);
    regRead(`TPM_STAT_ADDR);
    `CHK("status mode ro", 2'h0, rdVal[3:2])
    regRead(8'h08);
    `CHK("unmapped read", 32'h0000_0000, rdVal)
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      for (int h = 0; h < 2; h++) begin
        ctrl = 32'h0000_0001 | (32'(m) << `TPM_MODE_LSB) | (32'(h) << `TPM_HALF_BIT);
        regWrite(`TPM_CTRL_ADDR, ctrl);
        regRead(`TPM_CTRL_ADDR);
        `CHK("ctrl mirror", ctrl, rdVal)
        regRead(`TPM_STAT_ADDR);
        `CHK("status mode", 2'(m), rdVal[3:2])
        `CHK("half ignored", (m == 1 && h == 1), rdVal[`TPM_ST_HALF_IGN])
        `CHK("rate advisory", (m == 1), rdVal[`TPM_ST_RATE_ADV])
        `CHK("status active", 1'b1, rdVal[`TPM_ST_ACTIVE])
        tick(3);
        for (int k = 0; k < 8; k++) begin
          tick(1);
          clkHist[k] = riseClk;
          bHist[k] = demuxB;
          if (m != 2 && !(m == 0 && h == 1)) begin
            `CHK("full clock rise", 1'b1, riseClk)
            `CHK("full clock fall", 1'b0, fallClk)
          end else begin
            `CHK("clock both halves", riseClk, fallClk)
          end
          if (m == 0) begin
            `CHK("normal pins", stim - 20'h0_0001, pinRise)
          end else if (m == 1) begin
            `CHK("mux decode", stim - 20'h0_0001, muxTrace)
          end else begin
            `CHK("demux pair", demuxB + 20'h0_0001, demuxA)
            `CHK("demux rise fall", pinRise, pinFall)
          end
        end
        step = (m == 2 && h == 1) ? 2 : 1;
        for (int k = 2; k < 8; k++) begin
          if (m == 2 || h == 1 && m == 0) begin
            `CHK("clock period", ~clkHist[k-step], clkHist[k])
          end
          if (m == 2 && bHist[k] !== bHist[k-1]) begin
            `CHK("demux step", bHist[k-1] + 20'h0_0002, bHist[k])
            `CHK("demux hold", bHist[k-2], bHist[k-1])
          end
        end
        $display("test mode %0d half %0d done", m, h);
      end
    end
    regWrite(`TPM_CTRL_ADDR, 32'h0003_0001);
    tick(3);
    `CHK("off pins", 20'h0_0000, pinRise)
    `CHK("off port b", 20'h0_0000, portB)
    `CHK("off clock", 1'b0, clkRise)
    regRead(`TPM_STAT_ADDR);
    `CHK("off mode flag", 1'b1, rdVal[`TPM_ST_MODE_BAD])
    `CHK("off inactive", 1'b0, rdVal[`TPM_ST_ACTIVE])
    $display("test mode off done");
    regWrite(`TPM_CTRL_ADDR, 32'h0000_0001);
    tick(3);
    @(posedge sys_clk);
    jtagTraceEnable <= 1'b0;
    tick(1);
    `CHK("sync lag", 1'b1, clkRise)
    tick(6);
    `CHK("jtag off clock", 1'b0, clkRise)
    `CHK("jtag off pins", 20'h0_0000, pinRise)
    regRead(`TPM_STAT_ADDR);
    `CHK("jtag status", 1'b0, rdVal[`TPM_ST_JTAG_EN])
    @(posedge sys_clk);
    jtagTraceEnable <= 1'b1;
    $display("test jtag done");
    regWrite(`TPM_CTRL_ADDR, 32'h0002_0003);
    tick(4);
    @(posedge sys_clk);
    rst <= 1'b1;
    #1;
    `CHK("async reset b", 20'h0_0000, portB)
    `CHK("async reset clk", 1'b0, clkRise)
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    regRead(`TPM_CTRL_ADDR);
    `CHK("ctrl after reset", `TPM_CTRL_RST, rdVal)
    $display("test reset again done");
    wrapUp();
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    numErrors++;
    wrapUp();
  end
endmodule : testbench
`default_nettype wire

// ==== verif/tpm_analyser_model.sv ====
// trace capture analyser model: samples the trace pins mid-way through both halves of each core clock cycle
`timescale 1ns/1ps
`default_nettype none
`include "tpm_defines.svh"
module tpm_analyser_model (
  input wire logic sys_clk,
  input wire logic [`TPM_PINS-1:0] pinRise,
  input wire logic [`TPM_PINS-1:0] pinFall,
  input wire logic [`TPM_PINS-1:0] portB,
  input wire logic clkRise,
  input wire logic clkFall,
  output var tpm_pkg::tpm_trace_s muxTrace,
  output logic [`TPM_PINS-1:0] demuxB,
  output logic [`TPM_PINS-1:0] demuxA,
  output logic riseClk,
  output logic fallClk
);
  import tpm_pkg::*;
  logic [`TPM_PINS-1:0] pinLevel;
  logic [`TPM_PINS-1:0] fallSmp;
  logic trace_output_clock;
  // pad cell view: rise value while the core clock is high, fall value while low
  assign pinLevel = sys_clk ? pinRise : pinFall;
  assign trace_output_clock = sys_clk ? clkRise : clkFall;
  // sample mid-slot, where data launched on either edge has settled
  always @(posedge sys_clk) begin
    #2.5;
    demuxA = pinLevel;
    demuxB = portB;
    riseClk = trace_output_clock;
    #5;
    fallSmp = pinLevel;
    fallClk = trace_output_clock;
  end
  always_comb begin
    muxTrace.pipelineStatus = demuxA[2:0];
    muxTrace.traceSyncFlag = fallSmp[0];
    muxTrace.tracePacketBus[0] = demuxA[3];
    muxTrace.tracePacketBus[3:1] = fallSmp[3:1];
    for (int i = 0; i < `TPM_MUX_PAIRS; i++) begin
      muxTrace.tracePacketBus[4+2*i] = demuxA[4+i];
      muxTrace.tracePacketBus[5+2*i] = fallSmp[4+i];
    end
  end
endmodule : tpm_analyser_model
`default_nettype wire
